// File: logic/remc_codec.sv
// Radio event message codec: parses remote call requests, builds replies and broadcasts.
// Assumes the link layer delivers request bytes one per cycle with a frame-end flag
// (checksum already removed and checked) and adds the checksum to outgoing frames.
`timescale 1ns/1ps
`default_nettype none
module remc_codec #(
   parameter int          MEM_BYTES = 64,
   parameter int          MAX_PASS  = 32,
   parameter int          MAX_RET   = 32,
   parameter int          IND_MAX_N = 4,
   parameter int          FIFO_D    = 4
) (
   input  wire logic                    MCLK_IN,
   input  wire logic                    RESETN_IN,
   // Request byte stream from link
   input  wire logic [7:0]              RX_DATA_IN,
   input  wire logic                    RX_VALID_IN,
   input  wire logic                    RX_LAST_IN,
   // Function execution handshake
   output logic                         CALL_START_OUT,
   output logic [7:0]                   CALL_FUNC_OUT,
   output logic [15:0]                  CALL_PTR_OUT,
   input  wire logic                    CALL_DONE_IN,
   // Broadcast enables and events
   input  wire logic [6:0]              BC_ENABLE_IN,
   input  wire logic [6:0]              BC_EVENT_IN,
   input  wire logic [IND_MAX_N*8-1:0]  IND_TYPES_IN,
   input  wire logic [IND_MAX_N*2-1:0]  IND_STATES_IN,
   input  wire logic [2:0]              IND_COUNT_IN,
   input  wire logic [1:0]              BACKLIGHT_IN,
   input  wire logic [1:0]              BRIGHT_IN,
   input  wire logic                    ALERT_START_IN,
   input  wire logic [7:0]              ALERT_TYPE_IN,
   input  wire logic [23:0]             ERRLOG_IN,
   input  wire logic [15:0]             SILENT_MS_IN,
   input  wire logic [15:0]             PREAMBLES_IN,
   input  wire logic [2:0]              PACKETS_IN,
   input  wire logic [7:0]              DATALEN_IN,
   output logic                         BURST_RD_OUT,
   input  wire logic [7:0]              BURST_DATA_IN,
   input  wire logic                    SQ_START_IN,
   input  wire logic [7:0]              SQ_TYPE_IN,
   input  wire logic [7:0]              SQ_CODE_IN,
   // Outgoing byte stream to link
   output logic [7:0]                   TX_DATA_OUT,
   output logic                         TX_VALID_OUT,
   output logic                         TX_FIRST_OUT,
   input  wire logic                    TX_READY_IN,
   output logic                         CALL_ERROR_OUT
);
   localparam int AW = $clog2(MEM_BYTES);
   initial begin
      if (MAX_PASS + MAX_RET > MEM_BYTES || IND_MAX_N < 1 || IND_MAX_N > 7) begin
         $error("remc_codec parameters out of range");
      end
   end

   typedef enum logic [8:0] {
      S_IDLE  = 9'h001, S_FUNC = 9'h002, S_PHDR = 9'h004, S_PDAT = 9'h008,
      S_EXEC  = 9'h010, S_RHDR = 9'h020, S_WAIT = 9'h040, S_BCAST = 9'h080,
      S_DRAIN = 9'h100
   } remc_state_t;
   remc_state_t state;

   // Parsed parameter table, one slot per parameter
   localparam int NP = 8;
   logic [7:0]  p_hdr  [NP];
   logic [15:0] p_val  [NP];
   logic [15:0] p_ret  [NP];
   logic [15:0] p_addr [NP];
   logic [7:0]  pram   [MEM_BYTES];
   logic [2:0]  np;
   logic [2:0]  pidx;
   logic [15:0] cnt;
   logic [15:0] plen;
   logic [AW:0] alloc;
   logic [7:0]  func;
   logic        bad;
   logic [9:0]  olen;
   logic [9:0]  opos;
   logic [2:0]  next_cur;
   logic [6:0]  pend;
   logic [2:0]  cur;
   logic [7:0]  ob;
   logic        ob_first;
   logic        ob_valid;
   logic        f_ready;
   logic        f_valid;
   logic [7:0]  f_data;
   logic        burst_sel;

   // Byte count of one parameter's data as sent by the host, for every type but T_HPTR (sized by the parser)
   function automatic logic [15:0] fixed_len(input logic [6:0] t);
      if (t == remc_pkg::T_BYTE || t == remc_pkg::T_CHAR) begin
         fixed_len = 16'h0001;
      end else if (t == remc_pkg::T_VOID) begin
         fixed_len = 16'h0000;
      end else begin
         fixed_len = 16'h0002;
      end
   endfunction

   // Reply length: function byte plus each reported parameter
   logic [9:0] reply_len;
   always_comb begin
      reply_len = 10'h001;
      for (int i = 0; i < NP; i++) begin
         if (i < np && p_hdr[i][7]) begin
            if (p_hdr[i][6:0] == remc_pkg::T_HPTR) begin
               reply_len = reply_len + 10'(5) + 10'(p_ret[i]);
            end else begin
               reply_len = reply_len + 10'(1) + 10'(fixed_len(p_hdr[i][6:0]));
            end
         end
      end
   end

   // Request parser and executor
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         state <= S_IDLE; np <= '0; pidx <= '0; cnt <= '0; plen <= '0;
         alloc <= '0; func <= '0; bad <= 1'b0; CALL_START_OUT <= 1'b0; cur <= '0;
         CALL_FUNC_OUT <= '0; CALL_PTR_OUT <= '0; CALL_ERROR_OUT <= 1'b0;
         for (int i = 0; i < NP; i++) begin
            p_hdr[i] <= '0; p_val[i] <= '0; p_ret[i] <= '0; p_addr[i] <= '0;
         end
      end else begin
         CALL_START_OUT <= 1'b0;
         case (state)
            S_IDLE: begin
               if (RX_VALID_IN && RX_DATA_IN == remc_pkg::OP_CALL && !RX_LAST_IN) begin
                  state <= S_FUNC; np <= '0; alloc <= '0; bad <= 1'b0;
                  CALL_ERROR_OUT <= 1'b0;
               end else if (pend != '0) begin
                  state <= S_BCAST;
                  cur <= next_cur;
               end
            end
            S_FUNC: begin
               if (RX_VALID_IN) begin
                  func <= RX_DATA_IN;
                  state <= RX_LAST_IN ? S_EXEC : S_PHDR;
               end
            end
            S_PHDR: begin
               if (RX_VALID_IN) begin
                  p_hdr[np] <= RX_DATA_IN;
                  p_val[np] <= '0; p_ret[np] <= '0; cnt <= '0;
                  p_addr[np] <= 16'(alloc);
                  plen <= fixed_len(RX_DATA_IN[6:0]);
                  if ((RX_DATA_IN[6:0] == remc_pkg::T_VOID && np != '0) ||
                      RX_DATA_IN[6:0] > remc_pkg::T_HPTR) begin
                     bad <= 1'b1;
                  end
                  if (RX_DATA_IN[6:0] == remc_pkg::T_HPTR) begin
                     plen <= 16'h0004;
                  end
                  if (RX_LAST_IN) begin
                     np <= np + 1'b1; state <= S_EXEC;
                  end else if (RX_DATA_IN[6:0] != remc_pkg::T_VOID) begin
                     state <= S_PDAT;
                  end else begin
                     np <= np + 1'b1;
                  end
               end
            end
            S_PDAT: begin
               if (RX_VALID_IN) begin
                  cnt <= cnt + 16'h0001;
                  if (p_hdr[np][6:0] == remc_pkg::T_HPTR && cnt < 16'h0002) begin
                     p_ret[np] <= {p_ret[np][7:0], RX_DATA_IN};
                  end else if (p_hdr[np][6:0] == remc_pkg::T_HPTR && cnt < 16'h0004) begin
                     p_val[np] <= {p_val[np][7:0], RX_DATA_IN};
                     if (cnt == 16'h0003) begin
                        plen <= 16'h0004 + {p_val[np][7:0], RX_DATA_IN};
                        if ({p_val[np][7:0], RX_DATA_IN} > 16'(MAX_PASS) ||
                            p_ret[np] > 16'(MAX_RET)) begin
                           bad <= 1'b1;
                        end
                        alloc <= alloc + (AW+1)'(MAX_RET);
                     end
                  end else if (p_hdr[np][6:0] == remc_pkg::T_HPTR) begin
                     if (!bad) begin
                        pram[AW'(p_addr[np] + cnt - 16'h0004)] <= RX_DATA_IN;
                     end
                  end else begin
                     p_val[np] <= {p_val[np][7:0], RX_DATA_IN};
                  end
                  if (RX_LAST_IN || (cnt + 16'h0001 == plen && !(cnt == 16'h0003 &&
                      {p_val[np][7:0], RX_DATA_IN} != 16'h0000))) begin
                     np <= np + 1'b1;
                     state <= RX_LAST_IN ? S_EXEC : S_PHDR;
                     if (cnt + 16'h0001 != plen || np == 3'(NP-1)) begin
                        bad <= 1'b1;
                     end
                  end
               end
            end
            S_EXEC: begin
               // Host waits for the reply before the next request
               if (bad) begin
                  CALL_ERROR_OUT <= 1'b1; state <= S_IDLE;
               end else begin
                  CALL_FUNC_OUT <= func; CALL_START_OUT <= 1'b1;
                  CALL_PTR_OUT <= p_addr[0];
                  state <= S_WAIT;
               end
            end
            S_WAIT: state <= CALL_DONE_IN ? S_RHDR : S_WAIT;
            S_RHDR, S_BCAST: begin
               if (ob_valid && f_ready && opos + 10'h001 == olen) begin
                  state <= S_IDLE;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // Broadcast pending flags, set wins over clear
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         pend <= '0;
      end else begin
         for (int i = 0; i < remc_pkg::BC_COUNT; i++) begin
            if (BC_EVENT_IN[i] && BC_ENABLE_IN[i]) begin
               pend[i] <= 1'b1;
            end else if (state == S_BCAST && cur == 3'(i) && ob_valid && f_ready &&
                         opos + 10'h001 == olen) begin
               pend[i] <= 1'b0;
            end
         end
      end
   end

   // Lowest pending broadcast is sent first
   always_comb begin
      next_cur = '0;
      for (int i = remc_pkg::BC_COUNT - 1; i >= 0; i--) begin
         if (pend[i]) begin
            next_cur = 3'(i);
         end
      end
   end

   // Frame length, excluding header bytes
   logic [9:0] bc_len;
   always_comb begin
      case (cur)
         3'(remc_pkg::BC_IND):  bc_len = 10'h002 + 10'({IND_COUNT_IN, 1'b0});
         3'(remc_pkg::BC_BACK): bc_len = 10'h002;
         3'(remc_pkg::BC_BRIGHT): bc_len = 10'h002;
         3'(remc_pkg::BC_ALERT): bc_len = 10'h003;
         3'(remc_pkg::BC_ERR):  bc_len = 10'h004;
         3'(remc_pkg::BC_BURST): bc_len = 10'h007 + 10'(remc_pkg::BLK_BYTES) *
                                 (10'(PACKETS_IN) + 10'(DATALEN_IN));
         default:               bc_len = 10'h004;
      endcase
   end

   // Frame byte generator
   logic [9:0]  body_len;
   logic [9:0]  k;
   logic        is_long;
   logic [7:0]  opcode;
   always_comb begin
      body_len = (state == S_BCAST) ? bc_len : reply_len + 10'h001;
      opcode = OP_of(cur);
      if (state != S_BCAST) begin
         opcode = remc_pkg::OP_CALL;
      end
      is_long = body_len >= 10'(remc_pkg::LONG_MIN);
      k = opos - (is_long ? 10'h003 : 10'h001);
      ob_first = opos == '0;
      ob = '0;
      burst_sel = 1'b0;
      if (opos == '0) begin
         ob = is_long ? remc_pkg::LEN_LONG : {remc_pkg::LEN_SHORT, body_len[3:0]};
      end else if (is_long && opos == 10'h001) begin
         ob = {6'h00, body_len[9:8]};
      end else if (is_long && opos == 10'h002) begin
         ob = body_len[7:0];
      end else if (k == '0) begin
         ob = opcode;
      end else if (state != S_BCAST) begin
         ob = reply_byte(k - 10'h001);
      end else begin
         case (cur)
            3'(remc_pkg::BC_IND): begin
               if (k == 10'h001) ob = {5'h00, IND_COUNT_IN};
               else if (k <= 10'(IND_COUNT_IN) + 10'h001)
                  ob = IND_TYPES_IN[8*(k-10'h002) +: 8];
               else
                  ob = {6'h00, IND_STATES_IN[2*(k-10'h002-10'(IND_COUNT_IN)) +: 2]};
            end
            3'(remc_pkg::BC_BACK):   ob = {6'h00, BACKLIGHT_IN};
            3'(remc_pkg::BC_BRIGHT): ob = {6'h00, BRIGHT_IN};
            3'(remc_pkg::BC_ALERT):
               ob = (k == 10'h001) ? (ALERT_START_IN ? remc_pkg::ACT_START
                                      : remc_pkg::ACT_STOP) : ALERT_TYPE_IN;
            3'(remc_pkg::BC_ERR):    ob = ERRLOG_IN[8*(3-k) +: 8];
            3'(remc_pkg::BC_BURST): begin
               if (k <= 10'h002)      ob = SILENT_MS_IN[8*(2-k) +: 8];
               else if (k <= 10'h004) ob = PREAMBLES_IN[8*(4-k) +: 8];
               else if (k == 10'h005) ob = {5'h00, PACKETS_IN};
               else if (k == 10'h006) ob = DATALEN_IN;
               else begin
                  ob = BURST_DATA_IN; burst_sel = 1'b1;
               end
            end
            default:
               ob = (k == 10'h001) ? (SQ_START_IN ? remc_pkg::ACT_START
                     : remc_pkg::ACT_STOP) : (k == 10'h002) ? SQ_TYPE_IN : SQ_CODE_IN;
         endcase
      end
      olen = body_len + (is_long ? 10'h003 : 10'h001);
   end

   function automatic logic [7:0] OP_of(input logic [2:0] c);
      case (c)
         3'(remc_pkg::BC_IND):    OP_of = remc_pkg::OP_IND;
         3'(remc_pkg::BC_BACK):   OP_of = remc_pkg::OP_BACKLIGHT;
         3'(remc_pkg::BC_BRIGHT): OP_of = remc_pkg::OP_BRIGHT;
         3'(remc_pkg::BC_ALERT):  OP_of = remc_pkg::OP_ALERT;
         3'(remc_pkg::BC_ERR):    OP_of = remc_pkg::OP_ERRLOG;
         3'(remc_pkg::BC_BURST):  OP_of = remc_pkg::OP_BURST;
         default:                 OP_of = remc_pkg::OP_SQUELCH;
      endcase
   endfunction

   // Reply byte j after the opcode: function number then reported parameters
   function automatic logic [7:0] reply_byte(input logic [9:0] j);
      logic [9:0] base;
      logic [9:0] rel;
      base = 10'h001;
      rel = '0;
      reply_byte = func;
      for (int i = 0; i < NP; i++) begin
         if (i < np && p_hdr[i][7] && j >= base) begin
            rel = j - base;
            if (rel == '0) reply_byte = p_hdr[i];
            else if (p_hdr[i][6:0] == remc_pkg::T_HPTR) begin
               if (rel <= 10'h002)      reply_byte = p_addr[i][8*(2-rel) +: 8];
               else if (rel <= 10'h004) reply_byte = p_ret[i][8*(4-rel) +: 8];
               else reply_byte = pram[AW'(p_addr[i] + 16'(rel) - 16'h0005)];
               base = base + 10'(5) + 10'(p_ret[i]);
               continue;
            end else if (fixed_len(p_hdr[i][6:0]) == 16'h0001) reply_byte = p_val[i][7:0];
            else reply_byte = p_val[i][8*(2-rel) +: 8];
            base = base + 10'(1) + 10'(fixed_len(p_hdr[i][6:0]));
         end else if (i < np && p_hdr[i][7]) begin
            base = base + ((p_hdr[i][6:0] == remc_pkg::T_HPTR) ? 10'(5) + 10'(p_ret[i])
                           : 10'(1) + 10'(fixed_len(p_hdr[i][6:0])));
         end
      end
   endfunction

   // Output position; one whole frame at a time
   assign ob_valid = (state == S_RHDR) || (state == S_BCAST);
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         opos <= '0;
         BURST_RD_OUT <= 1'b0;
      end else begin
         BURST_RD_OUT <= ob_valid && f_ready && burst_sel;
         if (!ob_valid) begin
            opos <= '0;
         end else if (f_ready) begin
            opos <= (opos + 10'h001 == olen) ? '0 : opos + 10'h001;
         end
      end
   end

   logic [8:0] f_word;
   remc_fifo #(.WIDTH(9), .DEPTH(FIFO_D)) u_fifo (
      .clk_in       (MCLK_IN),
      .rst_n_in     (RESETN_IN),
      .wr_data_in   ({ob_first, ob}),
      .wr_valid_in  (ob_valid),
      .wr_ready_out (f_ready),
      .rd_data_out  (f_word),
      .rd_valid_out (f_valid),
      .rd_ready_in  (!TX_VALID_OUT || TX_READY_IN)
   );
   assign f_data = f_word[7:0];

   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         TX_VALID_OUT <= 1'b0; TX_DATA_OUT <= '0; TX_FIRST_OUT <= 1'b0;
      end else if (!TX_VALID_OUT || TX_READY_IN) begin
         TX_VALID_OUT <= f_valid;
         TX_DATA_OUT  <= f_data;
         TX_FIRST_OUT <= f_word[8];
      end
   end
endmodule
`default_nettype wire

// File: logic/remc_pkg.sv
// Constants for the radio event message codec.
// Assumes a single system clock and a byte-wide message stream on both sides.
package remc_pkg;
   localparam logic [7:0] OP_CALL      = 8'h20;
   localparam logic [7:0] OP_IND       = 8'h21;
   localparam logic [7:0] OP_BACKLIGHT = 8'h22;
   localparam logic [7:0] OP_BRIGHT    = 8'h23;
   localparam logic [7:0] OP_ALERT     = 8'h24;
   localparam logic [7:0] OP_ERRLOG    = 8'h25;
   localparam logic [7:0] OP_BURST     = 8'h27;
   localparam logic [7:0] OP_SQUELCH   = 8'h29;
   localparam logic [3:0] LEN_SHORT    = 4'hF;
   localparam logic [7:0] LEN_LONG     = 8'hFF;
   localparam logic [4:0] LONG_MIN     = 5'h0F;
   localparam logic [6:0] T_VOID       = 7'h00;
   localparam logic [6:0] T_BYTE       = 7'h01;
   localparam logic [6:0] T_CHAR       = 7'h02;
   localparam logic [6:0] T_BOOL       = 7'h03;
   localparam logic [6:0] T_SHORT      = 7'h04;
   localparam logic [6:0] T_INT        = 7'h05;
   localparam logic [6:0] T_TPTR       = 7'h06;
   localparam logic [6:0] T_HPTR       = 7'h07;
   localparam logic [7:0] BOOL_TRUE    = 8'h01;
   localparam logic [2:0] PKT_MIN      = 3'h1;
   localparam logic [2:0] PKT_MAX      = 3'h4;
   localparam logic [2:0] BLK_BYTES    = 3'h6;
   localparam logic [7:0] ACT_STOP     = 8'h00;
   localparam logic [7:0] ACT_START    = 8'h01;
   localparam logic [7:0] SQ_MAX_TYPE  = 8'h04;
   localparam logic [1:0] IND_MAX      = 2'h3;
   localparam logic [1:0] LEVEL_MAX    = 2'h3;
   localparam int         BC_COUNT     = 7;
   localparam int         BC_IND       = 0;
   localparam int         BC_BACK      = 1;
   localparam int         BC_BRIGHT    = 2;
   localparam int         BC_ALERT     = 3;
   localparam int         BC_ERR       = 4;
   localparam int         BC_BURST     = 5;
   localparam int         BC_SQ        = 6;
endpackage

// File: logic/remc_fifo.sv
// Byte FIFO between frame builder and serial link.
// Assumes both sides on the same clock.
`timescale 1ns/1ps
`default_nettype none
module remc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   output logic      [WIDTH-1:0] rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   initial begin
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin
         $error("remc_fifo depth must be a power of two of at least 2");
      end
   end
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wp;
   logic [AW:0]      rp;
   logic             push;
   logic             pop;
   assign wr_ready_out = (wp - rp) != (AW+1)'(DEPTH);
   assign rd_valid_out = wp != rp;
   assign push         = wr_valid_in && wr_ready_out;
   assign pop          = rd_valid_out && rd_ready_in;
   assign rd_data_out  = mem[rp[AW-1:0]];
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wp[AW-1:0]] <= wr_data_in;
      end
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         wp <= '0;
         rp <= '0;
      end else begin
         if (push) begin
            wp <= wp + 1'b1;
         end
         if (pop) begin
            rp <= rp + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// File: test/remc_codec_checker.sv
// Checker on the codec's outgoing frame stream.
// Bound to remc_codec; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module remc_codec_checker (
   input wire logic       MCLK_IN,
   input wire logic       RESETN_IN,
   input wire logic [7:0] TX_DATA_OUT,
   input wire logic       TX_VALID_OUT,
   input wire logic       TX_FIRST_OUT,
   input wire logic       TX_READY_IN,
   input wire logic       CALL_START_OUT
);
   logic       acc;
   logic [7:0] n;
   logic [7:0] pos;
   logic [7:0] op;
   assign acc = TX_VALID_OUT && TX_READY_IN;
   // Short frame length, byte position and opcode of the frame in flight
   always_ff @(posedge MCLK_IN) begin
      if (!RESETN_IN) begin
         n <= 8'h00;
         pos <= 8'h01;
         op <= 8'h00;
      end else if (acc) begin
         n <= !TX_FIRST_OUT ? n : TX_DATA_OUT == 8'hFF ? 8'hFF : {4'h0, TX_DATA_OUT[3:0]};
         pos <= TX_FIRST_OUT ? 8'h01 : pos + 8'h01;
         op <= pos == 8'h01 && !TX_FIRST_OUT ? TX_DATA_OUT : op;
      end
   end
   default clocking dc @(posedge MCLK_IN);
   endclocking
   default disable iff (!RESETN_IN);
   tx_hold_a: assert property (TX_VALID_OUT && !TX_READY_IN |=> TX_VALID_OUT && $stable(TX_DATA_OUT)) else $error("stalled byte changed");
   hdr_nib_a: assert property (acc && TX_FIRST_OUT |-> TX_DATA_OUT[7:4] == 4'hF) else $error("bad header");
   frame_end_a: assert property (acc && TX_FIRST_OUT && n != 8'hFF |-> pos == n + 8'h01) else $error("frame cut");
   frame_len_a: assert property (acc && !TX_FIRST_OUT |-> n == 8'hFF || pos <= n) else $error("frame overran");
   call_pulse_a: assert property (CALL_START_OUT |=> !CALL_START_OUT) else $error("start held");
   level_val_a: assert property (acc && n != 8'hFF && pos == 8'h02 && op[7:1] == 7'h11 |-> TX_DATA_OUT <= 8'h03) else $error("bad level");
   action_val_a: assert property (acc && n != 8'hFF && pos == 8'h02 && (op == 8'h24 || op == 8'h29) |-> TX_DATA_OUT <= 8'h01) else $error("bad action");
   sq_type_a: assert property (acc && n != 8'hFF && pos == 8'h03 && op == 8'h29 |-> TX_DATA_OUT <= 8'h04) else $error("bad tone type");
endmodule
bind remc_codec remc_codec_checker chk (.MCLK_IN(MCLK_IN), .RESETN_IN(RESETN_IN),
   .TX_DATA_OUT(TX_DATA_OUT), .TX_VALID_OUT(TX_VALID_OUT), .TX_FIRST_OUT(TX_FIRST_OUT),
   .TX_READY_IN(TX_READY_IN), .CALL_START_OUT(CALL_START_OUT));
`default_nettype wire

// File: test/remc_link_model.sv
// Link-side model: collects outgoing bytes, stalls when asked.
// Runs on the codec clock and changes ready on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module remc_link_model (
   input  wire logic       clk_in,
   input  wire logic       slow_in,
   input  wire logic [7:0] data_in,
   input  wire logic       valid_in,
   output logic            ready_out
);
   logic [7:0] got[$];
   logic [1:0] cnt = 2'h0;
   initial ready_out = 1'b0;
   always @(negedge clk_in) cnt <= cnt + 2'h1;
   always @(negedge clk_in) ready_out <= !slow_in || cnt == 2'h3;
   always @(posedge clk_in) if (valid_in && ready_out) got.push_back(data_in);
endmodule
`default_nettype wire

// File: test/tb_radio_event_message_codec.sv
// Bench for the radio event message codec: broadcasts and remote calls.
// Expects the link model and the bound checker beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_radio_event_message_codec;
   logic        clk = 1'b0, rstn = 1'b0, rxv = 1'b0, rxl = 1'b0, done = 1'b0;
   logic        slow = 1'b0, act = 1'b0, start, rdy, txv, cerr, brd;
   logic [1:0]  lvl = 2'h0;
   logic [6:0]  ena = 7'h7F, ev = 7'h00;
   logic [7:0]  rxd = 8'h00, typ = 8'h00, bdat = 8'h00, func, txd;
   logic [15:0] ptr;
   int          err_total = 0, tests_run = 0;
   remc_codec uut (.MCLK_IN(clk), .RESETN_IN(rstn), .RX_DATA_IN(rxd), .RX_VALID_IN(rxv),
      .RX_LAST_IN(rxl), .CALL_START_OUT(start), .CALL_FUNC_OUT(func), .CALL_PTR_OUT(ptr),
      .CALL_DONE_IN(done), .BC_ENABLE_IN(ena), .BC_EVENT_IN(ev), .IND_TYPES_IN({24'h0, typ}),
      .IND_STATES_IN({6'h0, lvl}), .IND_COUNT_IN({1'b0, act, 1'b1}), .BACKLIGHT_IN(lvl),
      .BRIGHT_IN(lvl), .ALERT_START_IN(act), .ALERT_TYPE_IN(typ), .ERRLOG_IN({typ, 16'h2233}),
      .SILENT_MS_IN(16'h0000), .PREAMBLES_IN(16'h0000), .PACKETS_IN(3'h1), .DATALEN_IN(8'h00),
      .BURST_RD_OUT(brd), .BURST_DATA_IN(bdat), .SQ_START_IN(act), .SQ_TYPE_IN(typ),
      .SQ_CODE_IN(~typ), .TX_DATA_OUT(txd), .TX_VALID_OUT(txv), .TX_FIRST_OUT(),
      .TX_READY_IN(rdy), .CALL_ERROR_OUT(cerr));
   remc_link_model lm (.clk_in(clk), .slow_in(slow), .data_in(txd), .valid_in(txv),
      .ready_out(rdy));
   initial forever #2.5 clk = ~clk;
   // Burst data source steps to its next byte after each consumed one
   always @(negedge clk) if (brd) bdat <= bdat + 8'h01;
   task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic frame(int n, logic [39:0] exp);
      for (int i = 0; i < 400 && lm.got.size() < n; i++) @(negedge clk);
      for (int i = n - 1; i >= 0; i--) check("tx byte", lm.got.pop_front(), exp[8*i+:8]);
   endtask
   task automatic fire(int b);
      @(negedge clk) ev[b] = 1'b1;
      @(negedge clk) ev[b] = 1'b0;
   endtask
   task automatic t_bcast;
      slow = 1'b1;
      for (int i = 0; i < 4; i++) begin
         lvl = 2'(i);
         fire(1);
         frame(3, {16'hF222, 6'h0, lvl});
         fire(2);
         frame(3, {16'hF223, 6'h0, lvl});
      end
      fire(0);
      frame(5, {24'hF42101, typ, 6'h0, lvl});
      act = 1'b1;
      typ = 8'h05;
      fire(3);
      frame(4, {24'hF32401, typ});
      fire(4);
      frame(5, {16'hF425, typ, 16'h2233});
      slow = 1'b0;
      for (int i = 0; i < 5; i++) begin
         act = i[0];
         typ = 8'(i);
         fire(6);
         frame(5, {16'hF429, 7'h0, act, typ, ~typ});
      end
      fire(5);
      frame(5, 40'hFD27000000);
      frame(5, 40'h0001000001);
      frame(4, 40'h02030405);
      ena = 7'h00;
      fire(2);
      repeat (30) @(negedge clk);
      check("quiet", 8'(lm.got.size()), 8'h00);
      ena = 7'h7F;
      $display("broadcast test done");
   endtask
   task automatic send(int n, logic [71:0] b);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge clk) rxd = b[8*i+:8];
         rxv = 1'b1;
         rxl = i == 0;
      end
      @(negedge clk) rxv = 1'b0;
   endtask
   task automatic run(logic [7:0] f);
      for (int i = 0; i < 100 && start !== 1'b1; i++) @(negedge clk);
      check("start", {7'h0, start}, 8'h01);
      check("func", func, f);
      check("ptr", ptr, 16'h0000);
      @(negedge clk) done = 1'b1;
      @(negedge clk) done = 1'b0;
   endtask
   task automatic t_call;
      send(5, 40'h2037010500);
      repeat (20) @(negedge clk);
      check("error", {7'h0, cerr}, 8'h01);
      check("no reply", 8'(lm.got.size()), 8'h00);
      send(3, 24'h203700);
      run(8'h37);
      frame(3, 40'hF22037);
      check("error", {7'h0, cerr}, 8'h00);
      send(9, 72'h20008700020002AABB);
      run(8'h00);
      frame(5, 40'hF920008700);
      frame(5, 40'h000002AABB);
      $display("call test done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      t_bcast;
      t_call;
      wrap_up;
   end
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      wrap_up;
   end
endmodule
`default_nettype wire
